// ==== tccu_pkg.sv ====
// Shared constants and types of the timer capture and compare unit
package tccu_pkg;

  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [5:0] IDX_CAPTURE_ONE     = 6'h10;
  localparam logic [5:0] IDX_CAPTURE_TWO     = 6'h12;
  localparam logic [5:0] IDX_CAPTURE_THREE   = 6'h14;
  localparam logic [5:0] IDX_COMPARE_ONE     = 6'h16;
  localparam logic [5:0] IDX_COMPARE_TWO     = 6'h18;
  localparam logic [5:0] IDX_COMPARE_THREE   = 6'h1a;
  localparam logic [5:0] IDX_COMPARE_FOUR    = 6'h1c;
  localparam logic [5:0] IDX_SHARED_VALUE    = 6'h1e;
  localparam logic [5:0] IDX_PIN_ACTION      = 6'h20;
  localparam logic [5:0] IDX_EDGE_CONTROL    = 6'h21;
  localparam logic [5:0] IDX_IRQ_ENABLE      = 6'h22;
  localparam logic [5:0] IDX_FLAGS           = 6'h23;
  localparam logic [5:0] IDX_PULSE_ACCUM     = 6'h26;
  localparam logic [5:0] IDX_ONE_PIN_MASK    = 6'h0c;
  localparam logic [5:0] IDX_ONE_PIN_DATA    = 6'h0d;
  localparam int         ADDR_W              = 8;

  // ==========================================================
  // Field positions
  localparam int FLAG_COMPARE_ONE = 7;
  localparam int FLAG_SHARED      = 3;
  localparam int FLAG_CAPTURE_ONE = 2;
  localparam int EDGE_POS_FOUR    = 6;
  localparam int EDGE_POS_ONE     = 4;
  localparam int EDGE_POS_TWO     = 2;
  localparam int EDGE_POS_THREE   = 0;
  localparam int SHARED_SEL_POS   = 2;
  localparam int PIN_MASK_LOW     = 3;

  // ==========================================================
  // Reset values
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] SHARED_RESET  = 16'h0000;

  // ==========================================================
  // Encodings
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_LOW      = 2'h2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // Timer pin drive: bit 4 is compare one down to bit 0 compare five
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] drive;
  } tccu_pins_t;

endpackage

// ==== tccu_capture_chan.sv ====
// One input capture edge detector with its capture latch
`timescale 1ns/1ps
`default_nettype none
module tccu_capture_chan
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        pin,
  input  wire logic [1:0]  edge_sel,
  input  wire logic        chan_on,
  input  wire logic [15:0] counter,
  output logic             capture_evt,
  output logic [15:0]      capture_val
);
  import tccu_pkg::*;

  logic pin_q_r;
  logic hit;

  // ==========================================================
  // Edge qualification
  always_comb
  begin
    unique case (edge_sel)
      EDGE_OFF:  hit = 1'b0;
      EDGE_RISE: hit = pin & ~pin_q_r;
      EDGE_FALL: hit = ~pin & pin_q_r;
      default:   hit = pin ^ pin_q_r;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_q_r     <= 1'b0;
      capture_evt <= 1'b0;
    end
    else
    begin
      pin_q_r     <= pin;
      capture_evt <= hit & chan_on;
    end
  end

  // ==========================================================
  // Counter latch, whole word at once
  always_ff @(posedge mclk)
  begin
    if (hit & chan_on)
    begin
      capture_val <= counter;
    end
  end
endmodule
`default_nettype wire

// ==== tccu_top.sv ====
// Timer capture and compare unit with AXI4-Lite register access
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tccu_top
(
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic [15:0]                 free_running_counter,
  input  wire logic [2:0]                  capture_pins,
  input  wire logic                        shared_timer_pin,
  output tccu_pkg::tccu_pins_t             compare_pins,
  output logic                             capture_compare_irq,
  input  wire logic [tccu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [tccu_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import tccu_pkg::*;

  // ==========================================================
  // Declarations
  logic [15:0] compare_value_r [0:3];
  logic [15:0] shared_value_r;
  logic [7:0]  pin_action_r;
  logic [7:0]  edge_control_r;
  logic [7:0]  irq_enable_r;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic        shared_select_r;
  logic [7:0]  one_pin_mask_r;
  logic [7:0]  one_pin_data_r;
  logic [4:0]  match_q_r;
  logic [4:0]  match_now;
  logic [4:0]  match_evt;
  logic [3:0]  cap_evt;
  logic [15:0] cap_val [0:3];
  logic [3:0]  cap_on;
  logic [1:0]  edge_of [0:3];
  logic [3:0]  cap_pin;
  logic [4:0]  level_nxt;
  logic [4:0]  drive_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_held_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_held_r;
  logic              wr_go;
  logic [5:0]        wr_idx;
  logic [5:0]        rd_idx;
  logic [7:0]        wr_clear;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic              wr_hit;

  // ==========================================================
  // Capture channels: index 0..2 are channels one..three, 3 is four
  assign edge_of[0] = edge_control_r[EDGE_POS_ONE +: 2];
  assign edge_of[1] = edge_control_r[EDGE_POS_TWO +: 2];
  assign edge_of[2] = edge_control_r[EDGE_POS_THREE +: 2];
  assign edge_of[3] = edge_control_r[EDGE_POS_FOUR +: 2];
  assign cap_on     = {shared_select_r, 3'b111};
  assign cap_pin    = {shared_timer_pin, capture_pins};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_cap
      tccu_capture_chan u_cap
      (
        .mclk        (mclk),
        .srst        (srst),
        .pin         (cap_pin[g]),
        .edge_sel    (edge_of[g]),
        .chan_on     (cap_on[g]),
        .counter     (free_running_counter),
        .capture_evt (cap_evt[g]),
        .capture_val (cap_val[g])
      );
    end
  endgenerate

  // ==========================================================
  // Comparators, one per compare channel
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      match_now[4-i] = (compare_value_r[i] == free_running_counter);
    end
    match_now[0] = ~shared_select_r
                 & (shared_value_r == free_running_counter);
  end

  // New match only when equality begins, so a held count acts once
  assign match_evt = match_now & ~match_q_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      match_q_r <= 5'h00;
    end
    else
    begin
      match_q_r <= match_now;
    end
  end

  // ==========================================================
  // Flags
  always_comb
  begin
    flags_nxt = flags_r & ~wr_clear;
    flags_nxt[FLAG_COMPARE_ONE -: 4] = flags_nxt[FLAG_COMPARE_ONE -: 4]
                                     | match_evt[4:1];
    flags_nxt[FLAG_SHARED] = flags_nxt[FLAG_SHARED]
                           | match_evt[0]
                           | cap_evt[3];
    flags_nxt[FLAG_CAPTURE_ONE -: 3] = flags_nxt[FLAG_CAPTURE_ONE -: 3]
                                     | {cap_evt[0], cap_evt[1], cap_evt[2]};
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      flags_r <= CTRL_RESET;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // Request when an enabled flag stands; shared bit valid in either role
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      capture_compare_irq <= 1'b0;
    end
    else
    begin
      capture_compare_irq <= |(flags_r & irq_enable_r);
    end
  end

  // ==========================================================
  // Pin actions
  always_comb
  begin
    level_nxt = compare_pins.level;
    drive_nxt[4] = one_pin_mask_r[7];
    for (int i = 1; i < 5; i++)
    begin
      drive_nxt[4-i] = (pin_action_r[9-2*i -: 2] != ACT_NONE)
                     | one_pin_mask_r[7-i];
      if (match_evt[4-i])
      begin
        unique case (pin_action_r[9-2*i -: 2])
          ACT_NONE:   level_nxt[4-i] = compare_pins.level[4-i];
          ACT_TOGGLE: level_nxt[4-i] = ~compare_pins.level[4-i];
          ACT_LOW:    level_nxt[4-i] = 1'b0;
          default:    level_nxt[4-i] = 1'b1;
        endcase
      end
    end
    drive_nxt[0] = drive_nxt[0] & ~shared_select_r;
    if (match_evt[4])
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (one_pin_mask_r[7-i])
        begin
          level_nxt[4-i] = one_pin_data_r[7-i];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      compare_pins <= '0;
    end
    else
    begin
      compare_pins.level <= level_nxt;
      compare_pins.drive <= drive_nxt;
    end
  end

  // ==========================================================
  // AXI4-Lite write channels
  assign wr_go  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_idx = aw_addr_r[ADDR_W-1:2];

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_r     <= '0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    unique case (wr_idx)
      IDX_CAPTURE_ONE, IDX_CAPTURE_TWO, IDX_CAPTURE_THREE,
      IDX_COMPARE_ONE, IDX_COMPARE_TWO, IDX_COMPARE_THREE,
      IDX_COMPARE_FOUR, IDX_SHARED_VALUE, IDX_PIN_ACTION,
      IDX_EDGE_CONTROL, IDX_IRQ_ENABLE, IDX_FLAGS,
      IDX_PULSE_ACCUM, IDX_ONE_PIN_MASK, IDX_ONE_PIN_DATA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign wr_clear = (wr_go & (wr_idx == IDX_FLAGS) & w_strb_r[0])
                  ? w_data_r[7:0] : 8'h00;

  // ==========================================================
  // Register writes
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        compare_value_r[i] <= COMPARE_RESET;
      end
    end
    else if (wr_go)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wr_idx == IDX_COMPARE_ONE + 6'(2*i))
        begin
          if (w_strb_r[0]) compare_value_r[i][7:0]  <= w_data_r[7:0];
          if (w_strb_r[1]) compare_value_r[i][15:8] <= w_data_r[15:8];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      shared_value_r <= SHARED_RESET;
    end
    else if (cap_evt[3])
    begin
      shared_value_r <= cap_val[3];
    end
    else if (wr_go & (wr_idx == IDX_SHARED_VALUE))
    begin
      if (w_strb_r[0]) shared_value_r[7:0]  <= w_data_r[7:0];
      if (w_strb_r[1]) shared_value_r[15:8] <= w_data_r[15:8];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_action_r    <= CTRL_RESET;
      edge_control_r  <= CTRL_RESET;
      irq_enable_r    <= CTRL_RESET;
      shared_select_r <= 1'b0;
      one_pin_mask_r  <= CTRL_RESET;
      one_pin_data_r  <= CTRL_RESET;
    end
    else if (wr_go & w_strb_r[0])
    begin
      unique case (wr_idx)
        IDX_PIN_ACTION:   pin_action_r    <= w_data_r[7:0];
        IDX_EDGE_CONTROL: edge_control_r  <= w_data_r[7:0];
        IDX_IRQ_ENABLE:   irq_enable_r    <= w_data_r[7:0];
        IDX_PULSE_ACCUM:  shared_select_r <= w_data_r[SHARED_SEL_POS];
        IDX_ONE_PIN_MASK: one_pin_mask_r  <= {w_data_r[7:PIN_MASK_LOW], 3'h0};
        IDX_ONE_PIN_DATA: one_pin_data_r  <= {w_data_r[7:PIN_MASK_LOW], 3'h0};
        default:          ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      IDX_CAPTURE_ONE:   rd_word[15:0] = cap_val[0];
      IDX_CAPTURE_TWO:   rd_word[15:0] = cap_val[1];
      IDX_CAPTURE_THREE: rd_word[15:0] = cap_val[2];
      IDX_COMPARE_ONE:   rd_word[15:0] = compare_value_r[0];
      IDX_COMPARE_TWO:   rd_word[15:0] = compare_value_r[1];
      IDX_COMPARE_THREE: rd_word[15:0] = compare_value_r[2];
      IDX_COMPARE_FOUR:  rd_word[15:0] = compare_value_r[3];
      IDX_SHARED_VALUE:  rd_word[15:0] = shared_value_r;
      IDX_PIN_ACTION:    rd_word[7:0]  = pin_action_r;
      IDX_EDGE_CONTROL:  rd_word[7:0]  = edge_control_r;
      IDX_IRQ_ENABLE:    rd_word[7:0]  = irq_enable_r;
      IDX_FLAGS:         rd_word[7:0]  = flags_r;
      IDX_PULSE_ACCUM:   rd_word[SHARED_SEL_POS] = shared_select_r;
      IDX_ONE_PIN_MASK:  rd_word[7:0]  = one_pin_mask_r;
      IDX_ONE_PIN_DATA:  rd_word[7:0]  = one_pin_data_r;
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tccu_monitor.sv ====
// Bus handshake and reset checker for the capture and compare unit
`timescale 1ns/1ps
`default_nettype none
module tccu_monitor
(
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire tccu_pkg::tccu_pins_t compare_pins,
  input wire logic                 capture_compare_irq,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata
);
  import tccu_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // ==========
  // Assertions
  chk_reset_quiet:
  assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid
    && !capture_compare_irq && compare_pins.drive == 5'h0)
    else $error("outputs active after reset");
  chk_bvalid_holds:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_holds:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_aw_pulse:
  assert property (s_axi_awready |-> $past(s_axi_awvalid) ##1 !s_axi_awready)
    else $error("write address ready misplaced");
  chk_ar_pulse:
  assert property (s_axi_arready |-> $past(s_axi_arvalid) ##1 !s_axi_arready)
    else $error("read address ready misplaced");
  chk_b_after_take:
  assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2) || $past(s_axi_wready, 2))
    else $error("write response without accept");
  chk_r_after_take:
  assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read data without accept");
  chk_resp_codes:
  assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("illegal write response code");
endmodule
bind tccu_top tccu_monitor i_mon
(
  .mclk, .srst, .compare_pins, .capture_compare_irq, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
`default_nettype wire

// ==== tccu_pins_model.sv ====
// Far side: event lines into the unit and the loaded compare pins
`timescale 1ns/1ps
`default_nettype none
module tccu_pins_model
(
  input  wire tccu_pkg::tccu_pins_t compare_pins,
  input  wire logic                 mclk,
  output logic [2:0]                capture_pins,
  output logic                      shared_timer_pin,
  output logic [4:0]                pad
);
  import tccu_pkg::*;
  initial
  begin
    capture_pins = 3'h0;
    shared_timer_pin = 1'h0;
  end
  // Lines move together just after an edge
  task automatic set_all(input logic [3:0] l);
    @(posedge mclk);
    {shared_timer_pin, capture_pins} <= l;
  endtask
  // Released pins float to the pull-up
  assign pad = (compare_pins.level & compare_pins.drive) | ~compare_pins.drive;
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the capture and compare unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tccu_pkg::*;
  logic              mclk = 1'h0;
  logic              srst = 1'h1;
  logic [15:0]       free_running_counter = 16'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h0;
  logic [ADDR_W-1:0] s_axi_araddr = 8'h0;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'h0;
  logic              s_axi_wvalid = 1'h0;
  logic              s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0;
  logic              s_axi_rready = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic [2:0]        capture_pins;
  logic              shared_timer_pin, capture_compare_irq;
  tccu_pins_t        compare_pins;
  logic [4:0]        pad;
  int                num_errors = 0;
  int                cmp_count = 0;
  always #5 mclk = ~mclk;
  tccu_top i_dut
  (
    .mclk, .srst, .free_running_counter, .capture_pins, .shared_timer_pin, .compare_pins,
    .capture_compare_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  tccu_pins_model i_pins
  (
    .compare_pins, .mclk, .capture_pins, .shared_timer_pin, .pad
  );
  // ==========
  // Checking and bus tasks
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic dn;
    dn = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50 && !dn; n++)
    begin
      @(posedge mclk);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1)
      begin
        dn = 1'h1;
        s_axi_bready <= 1'h0;
        ck("bresp", 32'(er), 32'(s_axi_bresp));
      end
    end
    if (!dn)
    begin
      ck("write wait", 32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [5:0] ix, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic dn;
    dn = 1'h0;
    @(posedge mclk);
    s_axi_araddr <= {ix, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50 && !dn; n++)
    begin
      @(posedge mclk);
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1)
      begin
        dn = 1'h1;
        s_axi_rready <= 1'h0;
        ck("rdata", e, s_axi_rdata);
        ck("rresp", 32'(er), 32'(s_axi_rresp));
      end
    end
    if (!dn)
    begin
      ck("read wait", 32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic step(input logic [15:0] v, input logic [3:0] l);
    @(posedge mclk);
    free_running_counter <= v;
    i_pins.set_all(l);
    repeat (4) @(posedge mclk);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge mclk);
    ck("irq", 32'(e), 32'(capture_compare_irq));
  endtask
  function automatic logic hit(input logic [1:0] s, input logic r);
    return s == 2'h3 || (s == EDGE_RISE && r) || (s == EDGE_FALL && !r);
  endfunction
  function automatic logic act(input logic [1:0] a, input logic o);
    return a == ACT_TOGGLE ? ~o : a[0];
  endfunction
  // ==========
  // Main sequence
  initial
  begin
    int i;
    logic [5:0] ix;
    logic [31:0] d;
    logic [15:0] v;
    logic [1:0] a;
    logic lv;
    void'($urandom(32'h78c35343));
    repeat (10) @(posedge mclk);
    srst <= 1'h0;
    for (i = 0; i < 5; i++)
    begin
      ix = IDX_COMPARE_ONE + 6'(2 * i);
      rd(ix, 32'(i < 4 ? COMPARE_RESET : SHARED_RESET), RESP_OKAY);
      d = $urandom;
      wr(ix, d, RESP_OKAY);
      rd(ix, {16'h0, d[15:0]}, RESP_OKAY);
      wr(ix, 32'hffff, RESP_OKAY);
    end
    rd(IDX_EDGE_CONTROL, 32'h0, RESP_OKAY);
    // Shared value resets to zero and meets count zero in the compare role
    rd(IDX_FLAGS, 32'h1 << FLAG_SHARED, RESP_OKAY);
    wr(IDX_PULSE_ACCUM, 32'hffffffff, RESP_OKAY);
    rd(IDX_PULSE_ACCUM, 32'h4, RESP_OKAY);
    wr(6'h3f, 32'h1, RESP_SLVERR);
    rd(6'h3f, 32'h0, RESP_SLVERR);
    for (i = 0; i < 8; i++)
    begin
      a = 2'(i / 2);
      wr(IDX_EDGE_CONTROL, 32'(a) << EDGE_POS_ONE, RESP_OKAY);
      v = 16'($urandom) & 16'h7fff;
      step(v, 4'(~i & 1));
      wr(IDX_FLAGS, 32'hfb, RESP_OKAY);
      rd(IDX_FLAGS, 32'(hit(a, !i[0])) << FLAG_CAPTURE_ONE, RESP_OKAY);
      if (hit(a, !i[0]))
        rd(IDX_CAPTURE_ONE, 32'(v), RESP_OKAY);
      wr(IDX_FLAGS, 32'h4, RESP_OKAY);
    end
    wr(IDX_EDGE_CONTROL, 32'hff, RESP_OKAY);
    v = 16'($urandom) & 16'h7fff;
    step(v, 4'hf);
    rd(IDX_FLAGS, 32'hf, RESP_OKAY);
    for (i = 0; i < 3; i++)
      rd(IDX_CAPTURE_ONE + 6'(2 * i), 32'(v), RESP_OKAY);
    rd(IDX_SHARED_VALUE, 32'(v), RESP_OKAY);
    wr(IDX_IRQ_ENABLE, 32'h4, RESP_OKAY);
    irq_is(1'h1);
    wr(IDX_FLAGS, 32'h4, RESP_OKAY);
    irq_is(1'h0);
    wr(IDX_IRQ_ENABLE, 32'h8, RESP_OKAY);
    irq_is(1'h1);
    wr(IDX_PULSE_ACCUM, 32'h0, RESP_OKAY);
    wr(IDX_FLAGS, 32'hff, RESP_OKAY);
    step(v ^ 16'h1, 4'h7);
    rd(IDX_FLAGS, 32'h0, RESP_OKAY);
    irq_is(1'h0);
    wr(IDX_IRQ_ENABLE, 32'h40, RESP_OKAY);
    lv = 1'h0;
    for (i = 0; i < 5; i++)
    begin
      a = 2'(10'h0b5 >> (2 * i));
      wr(IDX_PIN_ACTION, 32'(a) << 6, RESP_OKAY);
      v = 16'h9000 + 16'(i);
      wr(IDX_COMPARE_TWO, 32'(v), RESP_OKAY);
      step(v, 4'h7);
      if (a != ACT_NONE)
        lv = act(a, lv);
      ck("drive", 32'(a != ACT_NONE), 32'(compare_pins.drive[3]));
      if (a != ACT_NONE)
        ck("pad", 32'(lv), 32'(pad[3]));
    end
    rd(IDX_FLAGS, 32'h40, RESP_OKAY);
    irq_is(1'h1);
    wr(IDX_ONE_PIN_MASK, 32'h88, RESP_OKAY);
    wr(IDX_ONE_PIN_DATA, 32'h08, RESP_OKAY);
    wr(IDX_PIN_ACTION, 32'h2, RESP_OKAY);
    wr(IDX_COMPARE_ONE, 32'ha000, RESP_OKAY);
    wr(IDX_SHARED_VALUE, 32'ha100, RESP_OKAY);
    wr(IDX_FLAGS, 32'hff, RESP_OKAY);
    step(16'ha000, 4'h7);
    ck("pins", 32'h22f, 32'({compare_pins.drive, pad}));
    step(16'ha100, 4'h7);
    ck("pins", 32'h22e, 32'({compare_pins.drive, pad}));
    rd(IDX_FLAGS, 32'h88, RESP_OKAY);
    wr(IDX_PULSE_ACCUM, 32'h4, RESP_OKAY);
    wr(IDX_FLAGS, 32'hff, RESP_OKAY);
    step(16'ha0ff, 4'h7);
    step(16'ha100, 4'h7);
    rd(IDX_FLAGS, 32'h0, RESP_OKAY);
    ck("pins", 32'h20f, 32'({compare_pins.drive, pad}));
    give_verdict();
  end
endmodule
`default_nettype wire
